/* File: rtl/tccb_params.svh */
// Register indices, field positions, reset values and timing for the timer clock/clear block
`ifndef TCCB_PARAMS_SVH
`define TCCB_PARAMS_SVH

// Word indices on the internal 16-bit register bus
`define TCCB_IDX_CCR 5'h00
`define TCCB_IDX_CNT 5'h05
`define TCCB_IDX_GRA 5'h0A
`define TCCB_IDX_GRB 5'h0F
`define TCCB_IDX_BUF_A3 5'h14
`define TCCB_IDX_BUF_B3 5'h15
`define TCCB_IDX_BUF_A4 5'h16
`define TCCB_IDX_BUF_B4 5'h17

// Count control fields
`define TCCB_CCR_FIXED_BIT 7
`define TCCB_CCR_CLR_HI 6
`define TCCB_CCR_CLR_LO 5
`define TCCB_CCR_EDGE_HI 4
`define TCCB_CCR_EDGE_LO 3
`define TCCB_CCR_SRC_EXT 2
`define TCCB_CCR_SRC_HI 1
`define TCCB_CCR_SRC_LO 0

// Reset values
`define TCCB_CCR_RESET 8'h80
`define TCCB_BUF_RESET 16'hFFFF
`define TCCB_GR_RESET 16'hFFFF
`define TCCB_CNT_RESET 16'h0000

// Prescaler: one enable of phi/8 every 8 cycles of phi
`define TCCB_DIV_PERIOD 8

`endif

/* File: rtl/tccb_pkg.sv */
// Types shared by the timer clock/clear block
package tccb_pkg;
    typedef enum logic [1:0] {
        TCCB_CLR_NONE = 2'b00,
        TCCB_CLR_A = 2'b01,
        TCCB_CLR_B = 2'b10,
        TCCB_CLR_SYNC = 2'b11
    } tccb_clear_t;
    typedef enum logic [1:0] {
        TCCB_EDGE_RISE = 2'b00,
        TCCB_EDGE_FALL = 2'b01,
        TCCB_EDGE_BOTH = 2'b10,
        TCCB_EDGE_BOTH2 = 2'b11
    } tccb_edge_t;
endpackage : tccb_pkg

/* File: rtl/tccb_top.sv */
// Clock select, counter clear and compare/capture for five 16-bit timer channels, with buffering on channels 3 and 4
`timescale 1ns/1ps
`default_nettype none
`include "tccb_params.svh"

module tccb_top (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic STANDBY,
    input wire logic [4:0] ADDR,
    input wire logic WR,
    input wire logic RD,
    input wire logic [1:0] BE,
    input wire logic [15:0] WDATA,
    output logic [15:0] RDATA,
    input wire logic EXT_CLOCK_A,
    input wire logic EXT_CLOCK_B,
    input wire logic EXT_CLOCK_C,
    input wire logic EXT_CLOCK_D,
    input wire logic BUFFER_EN_A_CH3,
    input wire logic BUFFER_EN_B_CH3,
    input wire logic BUFFER_EN_A_CH4,
    input wire logic BUFFER_EN_B_CH4,
    input wire logic [4:0] GR_A_CAPTURE,
    input wire logic [4:0] GR_B_CAPTURE,
    input wire logic [4:0] CAPTURE_A,
    input wire logic [4:0] CAPTURE_B,
    input wire logic [4:0] SYNC_SELECT,
    input wire logic PHASE_COUNT_ENABLE,
    input wire logic PHASE_UP,
    input wire logic PHASE_DOWN,
    output logic [4:0] MATCH_A,
    output logic [4:0] MATCH_B
);

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd, input logic [1:0] be);
        merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction : merge

    // One count enable for a channel from its control byte
    function automatic logic tick_sel(input logic [7:0] ccr, input logic [3:0] pre,
                                      input logic [3:0] rise, input logic [3:0] fall);
        logic [1:0] k;
        k = ccr[`TCCB_CCR_SRC_HI:`TCCB_CCR_SRC_LO];
        if (!ccr[`TCCB_CCR_SRC_EXT]) begin
            tick_sel = pre[k];
        end else begin
            case (tccb_pkg::tccb_edge_t'(ccr[`TCCB_CCR_EDGE_HI:`TCCB_CCR_EDGE_LO]))
                tccb_pkg::TCCB_EDGE_RISE: tick_sel = rise[k];
                tccb_pkg::TCCB_EDGE_FALL: tick_sel = fall[k];
                default: tick_sel = rise[k] | fall[k];
            endcase
        end
    endfunction : tick_sel

    logic [7:0] ccr_q [5];
    logic [15:0] cnt_q [5];
    logic [15:0] gra_q [5];
    logic [15:0] grb_q [5];
    logic [15:0] buf_a_q [2];
    logic [15:0] buf_b_q [2];
    logic [3:0] ext_pin;
    logic [3:0] sync1_q, sync2_q, sync3_q, lvl_q, rise, fall;
    logic [2:0] div_q;
    logic [3:0] pre;
    logic [4:0] tick, eq_a, eq_b, eq_a_q, eq_b_q, match_a, match_b, ev_a, ev_b, own_clr, clr;
    logic [4:0] buf_en_a, buf_en_b;
    logic any_sync;
    logic [4:0] wr_ccr, wr_cnt, wr_gra, wr_grb;
    logic [1:0] wr_bufa, wr_bufb;
    logic [15:0] rd_mux, rdata_q;

    assign ext_pin = {EXT_CLOCK_D, EXT_CLOCK_C, EXT_CLOCK_B, EXT_CLOCK_A};
    // Channels 0 to 2 have no buffers, so their enables are tied off
    assign buf_en_a = {BUFFER_EN_A_CH4, BUFFER_EN_A_CH3, 3'b000};
    assign buf_en_b = {BUFFER_EN_B_CH4, BUFFER_EN_B_CH3, 3'b000};

    // Pin synchroniser; a level counts once stages two and three agree
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            sync3_q <= 4'h0;
            lvl_q <= 4'h0;
        end else begin
            sync1_q <= ext_pin;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            for (int i = 0; i < 4; i++) begin
                if (sync2_q[i] == sync3_q[i]) begin
                    lvl_q[i] <= sync3_q[i];
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            rise[i] = (sync2_q[i] == sync3_q[i]) && sync3_q[i] && !lvl_q[i];
            fall[i] = (sync2_q[i] == sync3_q[i]) && !sync3_q[i] && lvl_q[i];
        end
    end

    // Prescaler; each enable marks the falling edge of the divided clock
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            div_q <= 3'h0;
        end else if (STANDBY) begin
            div_q <= 3'h0;
        end else begin
            div_q <= div_q + 3'h1;
        end
    end

    assign pre = {div_q == 3'h7, div_q[1:0] == 2'h3, div_q[0], 1'b1};

    // Register bus write decode
    always_comb begin
        wr_ccr = 5'h00;
        wr_cnt = 5'h00;
        wr_gra = 5'h00;
        wr_grb = 5'h00;
        wr_bufa = 2'h0;
        wr_bufb = 2'h0;
        if (WR) begin
            for (int c = 0; c < 5; c++) begin
                if (ADDR == 5'(`TCCB_IDX_CCR + c)) begin
                    wr_ccr[c] = BE[0];
                end else if (ADDR == 5'(`TCCB_IDX_CNT + c)) begin
                    wr_cnt[c] = 1'b1;
                end else if (ADDR == 5'(`TCCB_IDX_GRA + c)) begin
                    wr_gra[c] = 1'b1;
                end else if (ADDR == 5'(`TCCB_IDX_GRB + c)) begin
                    wr_grb[c] = 1'b1;
                end
            end
            if (ADDR == `TCCB_IDX_BUF_A3) begin
                wr_bufa[0] = 1'b1;
            end else if (ADDR == `TCCB_IDX_BUF_B3) begin
                wr_bufb[0] = 1'b1;
            end else if (ADDR == `TCCB_IDX_BUF_A4) begin
                wr_bufa[1] = 1'b1;
            end else if (ADDR == `TCCB_IDX_BUF_B4) begin
                wr_bufb[1] = 1'b1;
            end
        end
    end

    // Read mux; unmapped words read zero
    always_comb begin
        rd_mux = 16'h0000;
        for (int c = 0; c < 5; c++) begin
            if (ADDR == 5'(`TCCB_IDX_CCR + c)) begin
                rd_mux = {8'h00, ccr_q[c]};
            end else if (ADDR == 5'(`TCCB_IDX_CNT + c)) begin
                rd_mux = cnt_q[c];
            end else if (ADDR == 5'(`TCCB_IDX_GRA + c)) begin
                rd_mux = gra_q[c];
            end else if (ADDR == 5'(`TCCB_IDX_GRB + c)) begin
                rd_mux = grb_q[c];
            end
        end
        if (ADDR == `TCCB_IDX_BUF_A3) begin
            rd_mux = buf_a_q[0];
        end else if (ADDR == `TCCB_IDX_BUF_B3) begin
            rd_mux = buf_b_q[0];
        end else if (ADDR == `TCCB_IDX_BUF_A4) begin
            rd_mux = buf_a_q[1];
        end else if (ADDR == `TCCB_IDX_BUF_B4) begin
            rd_mux = buf_b_q[1];
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_q <= 16'h0000;
        end else if (RD) begin
            rdata_q <= rd_mux;
        end
    end

    assign RDATA = rdata_q;

    // Count control bytes
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int c = 0; c < 5; c++) ccr_q[c] <= `TCCB_CCR_RESET;
        end else begin
            for (int c = 0; c < 5; c++) begin
                if (STANDBY) begin
                    ccr_q[c] <= `TCCB_CCR_RESET;
                end else if (wr_ccr[c]) begin
                    ccr_q[c] <= {1'b1, WDATA[6:0]};
                end
            end
        end
    end

    // Compare matches and clear events
    always_comb begin
        for (int c = 0; c < 5; c++) begin
            eq_a[c] = cnt_q[c] == gra_q[c];
            eq_b[c] = cnt_q[c] == grb_q[c];
            // Only the first cycle of equality is a match, so a stalled count does not retrigger
            match_a[c] = !GR_A_CAPTURE[c] && eq_a[c] && !eq_a_q[c];
            match_b[c] = !GR_B_CAPTURE[c] && eq_b[c] && !eq_b_q[c];
            ev_a[c] = GR_A_CAPTURE[c] ? CAPTURE_A[c] : match_a[c];
            ev_b[c] = GR_B_CAPTURE[c] ? CAPTURE_B[c] : match_b[c];
            case (tccb_pkg::tccb_clear_t'(ccr_q[c][`TCCB_CCR_CLR_HI:`TCCB_CCR_CLR_LO]))
                tccb_pkg::TCCB_CLR_A: own_clr[c] = ev_a[c];
                tccb_pkg::TCCB_CLR_B: own_clr[c] = ev_b[c];
                default: own_clr[c] = 1'b0;
            endcase
            tick[c] = tick_sel(ccr_q[c], pre, rise, fall);
        end
        any_sync = |(own_clr & SYNC_SELECT);
        for (int c = 0; c < 5; c++) begin
            clr[c] = own_clr[c] || (ccr_q[c][`TCCB_CCR_CLR_HI:`TCCB_CCR_CLR_LO] == 2'b11
                                    && SYNC_SELECT[c] && any_sync);
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            eq_a_q <= 5'h00;
            eq_b_q <= 5'h00;
            MATCH_A <= 5'h00;
            MATCH_B <= 5'h00;
        end else begin
            eq_a_q <= eq_a;
            eq_b_q <= eq_b;
            MATCH_A <= match_a;
            MATCH_B <= match_b;
        end
    end

    // Counters; a bus write wins over counting and clearing
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int c = 0; c < 5; c++) cnt_q[c] <= `TCCB_CNT_RESET;
        end else begin
            for (int c = 0; c < 5; c++) begin
                if (STANDBY) begin
                    cnt_q[c] <= `TCCB_CNT_RESET;
                end else if (wr_cnt[c]) begin
                    cnt_q[c] <= merge(cnt_q[c], WDATA, BE);
                end else if (clr[c]) begin
                    cnt_q[c] <= 16'h0000;
                end else if (c == 2 && PHASE_COUNT_ENABLE) begin
                    if (PHASE_UP && !PHASE_DOWN) begin
                        cnt_q[c] <= cnt_q[c] + 16'h0001;
                    end else if (PHASE_DOWN && !PHASE_UP) begin
                        cnt_q[c] <= cnt_q[c] - 16'h0001;
                    end
                end else if (tick[c]) begin
                    cnt_q[c] <= cnt_q[c] + 16'h0001;
                end
            end
        end
    end

    // General registers: capture, buffered reload on match, bus write
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int c = 0; c < 5; c++) begin
                gra_q[c] <= `TCCB_GR_RESET;
                grb_q[c] <= `TCCB_GR_RESET;
            end
        end else begin
            for (int c = 0; c < 5; c++) begin
                if (STANDBY) begin
                    gra_q[c] <= `TCCB_GR_RESET;
                end else if (GR_A_CAPTURE[c] && CAPTURE_A[c]) begin
                    gra_q[c] <= cnt_q[c];
                end else if (match_a[c] && buf_en_a[c]) begin
                    gra_q[c] <= buf_a_q[1'(c - 3)];
                end else if (wr_gra[c]) begin
                    gra_q[c] <= merge(gra_q[c], WDATA, BE);
                end
                if (STANDBY) begin
                    grb_q[c] <= `TCCB_GR_RESET;
                end else if (GR_B_CAPTURE[c] && CAPTURE_B[c]) begin
                    grb_q[c] <= cnt_q[c];
                end else if (match_b[c] && buf_en_b[c]) begin
                    grb_q[c] <= buf_b_q[1'(c - 3)];
                end else if (wr_grb[c]) begin
                    grb_q[c] <= merge(grb_q[c], WDATA, BE);
                end
            end
        end
    end

    // Buffers of channels 3 and 4; a capture transfer wins over a bus write
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int j = 0; j < 2; j++) begin
                buf_a_q[j] <= `TCCB_BUF_RESET;
                buf_b_q[j] <= `TCCB_BUF_RESET;
            end
        end else begin
            for (int j = 0; j < 2; j++) begin
                if (STANDBY) begin
                    buf_a_q[j] <= `TCCB_BUF_RESET;
                end else if (buf_en_a[j + 3] && GR_A_CAPTURE[j + 3] && CAPTURE_A[j + 3]) begin
                    buf_a_q[j] <= gra_q[j + 3];
                end else if (wr_bufa[j]) begin
                    buf_a_q[j] <= merge(buf_a_q[j], WDATA, BE);
                end
                if (STANDBY) begin
                    buf_b_q[j] <= `TCCB_BUF_RESET;
                end else if (buf_en_b[j + 3] && GR_B_CAPTURE[j + 3] && CAPTURE_B[j + 3]) begin
                    buf_b_q[j] <= grb_q[j + 3];
                end else if (wr_bufb[j]) begin
                    buf_b_q[j] <= merge(buf_b_q[j], WDATA, BE);
                end
            end
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    AST_CCR_FIXED: assert property (wr_ccr[1] && !STANDBY |=> ccr_q[1][7] && ccr_q[1][6:0] == $past(WDATA[6:0]))
        else $error("control bit 7 not held at one after write");
    AST_STANDBY_INIT: assert property (STANDBY |=> ccr_q[4] == 8'h80 && buf_a_q[1] == 16'hFFFF && buf_b_q[0] == 16'hFFFF)
        else $error("standby did not initialise control and buffers");
    AST_BUF_TO_GR: assert property (match_a[3] && buf_en_a[3] && !STANDBY |=> gra_q[3] == $past(buf_a_q[0]))
        else $error("buffer not copied to general register on match");
    AST_GR_TO_BUF: assert property (buf_en_b[4] && GR_B_CAPTURE[4] && CAPTURE_B[4] && !STANDBY
                                    |=> buf_b_q[1] == $past(grb_q[4]) && grb_q[4] == $past(cnt_q[4]))
        else $error("capture did not shift old value into buffer");
    AST_NO_BUF: assert property (match_b[3] && !buf_en_b[3] && !wr_grb[3] && !STANDBY |=> $stable(grb_q[3]))
        else $error("general register reloaded while buffering off");
    AST_BYTE_WR: assert property (wr_bufb[0] && BE == 2'b01 && !STANDBY && !(buf_en_b[3] && GR_B_CAPTURE[3] && CAPTURE_B[3])
                                  |=> buf_b_q[0][15:8] == $past(buf_b_q[0][15:8]) && buf_b_q[0][7:0] == $past(WDATA[7:0]))
        else $error("byte write to buffer disturbed other lane");
    AST_CLEAR_B: assert property (ccr_q[1][6:5] == 2'b10 && ev_b[1] && !wr_cnt[1] && !STANDBY |=> cnt_q[1] == 16'h0000)
        else $error("counter not cleared on B event");
    // Sampled RST_N keeps the release edge out, where the counter still sits in reset
    AST_PHI: assert property (RST_N && ccr_q[1][2:0] == 3'b000 && !clr[1] && !wr_cnt[1] && !STANDBY
                              |=> cnt_q[1] == $past(cnt_q[1]) + 16'h0001)
        else $error("counter did not advance on phi");
    AST_DIV8: assert property (disable iff (!RST_N || STANDBY) pre[3] |=> !pre[3] [*7] ##1 pre[3])
        else $error("phi/8 enable spacing wrong");
    AST_EXT_PULSE: assert property (rise[0] |=> !rise[0] && lvl_q[0])
        else $error("external edge enable longer than one cycle");
    AST_PHASE: assert property (PHASE_COUNT_ENABLE && !PHASE_UP && !PHASE_DOWN && !clr[2] && !wr_cnt[2] && !STANDBY
                                |=> $stable(cnt_q[2]))
        else $error("channel 2 counted from clock fields in phase mode");
    AST_MATCH: assert property (match_a[1] |=> MATCH_A[1] ##1 !MATCH_A[1])
        else $error("match pulse not raised after equality");

endmodule : tccb_top
`default_nettype wire

/* File: sim/tccb_ext_clk_model.sv */
// Model of the four external clock pins, driving bursts of pulses
`timescale 1ns/1ps
`default_nettype none
module tccb_ext_clk_model (
    input wire logic clk,
    output logic [3:0] pins
);
    initial begin
        pins = 4'h0;
    end
    // Edges land 3 ns after CLK so they stay unrelated to sampling; pins stand still between bursts
    task automatic burst(input int sel, input int n, input int half);
        for (int i = 0; i < 2 * n; i++) begin
            @(posedge clk);
            #3;
            pins[sel] = ~pins[sel];
            repeat (half - 1) @(posedge clk);
        end
    endtask : burst
endmodule : tccb_ext_clk_model
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench for the timer clock/clear block
`timescale 1ns/1ps
`default_nettype none
`include "tccb_params.svh"
module tb_top;
    typedef struct {logic [4:0] idx; logic [1:0] be; logic [15:0] wd; logic [15:0] want;} tccb_row_t;
    logic clk = 1'b0, rst_n = 1'b0, standby = 1'b0, wr = 1'b0, rd = 1'b0;
    logic ph_en = 1'b0, ph_up = 1'b0, ph_dn = 1'b0;
    logic [4:0] addr = 5'h00, gra_cap = 5'h00, grb_cap = 5'h00, cap_a = 5'h00, cap_b = 5'h00, sync_sel = 5'h00;
    logic [1:0] be = 2'h0;
    logic [15:0] wdata = 16'h0000, rdata, rd_val;
    logic [3:0] pins, buf_en = 4'h0;
    logic [4:0] match_a, match_b;
    int n_fail = 0, cmp_count = 0, cycles = 0, na1 = 0, nb1 = 0, m0 = 0;
    tccb_row_t rows [9] = '{
        '{5'h00, 2'h1, 16'h007F, 16'h00FF},
        '{5'h01, 2'h3, 16'hFF00, 16'h0080},
        '{5'h02, 2'h2, 16'h0055, 16'h0080},
        '{`TCCB_IDX_BUF_A3, 2'h3, 16'h1234, 16'h1234},
        '{`TCCB_IDX_BUF_B3, 2'h1, 16'hAB56, 16'hFF56},
        '{`TCCB_IDX_BUF_A4, 2'h2, 16'hCD00, 16'hCDFF},
        '{`TCCB_IDX_BUF_B4, 2'h3, 16'h0000, 16'h0000},
        '{5'h1F, 2'h3, 16'h5A5A, 16'h0000},
        '{`TCCB_IDX_GRA, 2'h3, 16'h8000, 16'h8000}};

    tccb_top tccb_top_i (
        .CLK(clk), .RST_N(rst_n), .STANDBY(standby), .ADDR(addr), .WR(wr), .RD(rd), .BE(be),
        .WDATA(wdata), .RDATA(rdata), .EXT_CLOCK_A(pins[0]), .EXT_CLOCK_B(pins[1]),
        .EXT_CLOCK_C(pins[2]), .EXT_CLOCK_D(pins[3]), .BUFFER_EN_A_CH3(buf_en[0]),
        .BUFFER_EN_B_CH3(buf_en[1]), .BUFFER_EN_A_CH4(buf_en[2]), .BUFFER_EN_B_CH4(buf_en[3]),
        .GR_A_CAPTURE(gra_cap), .GR_B_CAPTURE(grb_cap), .CAPTURE_A(cap_a), .CAPTURE_B(cap_b),
        .SYNC_SELECT(sync_sel), .PHASE_COUNT_ENABLE(ph_en), .PHASE_UP(ph_up), .PHASE_DOWN(ph_dn),
        .MATCH_A(match_a), .MATCH_B(match_b)
    );
    tccb_ext_clk_model tccb_ext_clk_model_i (.clk(clk), .pins(pins));

    initial begin
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (match_a[1] === 1'b1) na1 <= na1 + 1;
        if (match_b[1] === 1'b1) nb1 <= nb1 + 1;
    end

    // Whole run needs about 1400 cycles; the ceiling leaves ample margin
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_fail++;
            results();
        end
    end

    task automatic results();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results

    task automatic bus_wr(input logic [4:0] idx, input logic [1:0] b, input logic [15:0] d);
        @(posedge clk);
        addr <= idx;
        be <= b;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [4:0] idx, output logic [15:0] d);
        @(posedge clk);
        addr <= idx;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : bus_rd

    task automatic chk16(input string what, input logic [15:0] want, input logic [15:0] got);
        cmp_count++;
        if (got !== want) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, want, got);
        end
    endtask : chk16

    task automatic chk_in(input string what, input int lo, input int hi, input logic [15:0] got);
        cmp_count++;
        if (((got >= lo) && (got <= hi)) !== 1'b1) begin
            n_fail++;
            $display("FAIL %s expected %0d..%0d seen %h", what, lo, hi, got);
        end
    endtask : chk_in

    task automatic chk_rd(input string what, input logic [4:0] idx, input logic [15:0] want);
        logic [15:0] d;
        bus_rd(idx, d);
        chk16(what, want, d);
    endtask : chk_rd

    task automatic step(input logic up, input logic dn);
        @(posedge clk);
        ph_up <= up;
        ph_dn <= dn;
        @(posedge clk);
        ph_up <= 1'b0;
        ph_dn <= 1'b0;
    endtask : step

    task automatic chk_defaults();
        for (int c = 0; c < 5; c++) begin
            chk_rd("count_control", 5'(c), 16'h0080);
            chk_rd("general_reg_a", 5'(`TCCB_IDX_GRA + c), 16'hFFFF);
        end
        for (int c = 0; c < 4; c++) begin
            chk_rd("buffer", 5'(`TCCB_IDX_BUF_A3 + c), 16'hFFFF);
        end
    endtask : chk_defaults

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        chk_defaults();
        foreach (rows[i]) begin
            bus_wr(rows[i].idx, rows[i].be, rows[i].wd);
            chk_rd("register row", rows[i].idx, rows[i].want);
        end
        // Divider phase is free-running, so a window of up to three ticks is allowed
        for (int s = 0; s < 4; s++) begin
            bus_wr(`TCCB_IDX_CCR, 2'h1, 16'(s));
            bus_wr(`TCCB_IDX_CNT, 2'h3, 16'h0000);
            repeat (64) @(posedge clk);
            bus_rd(`TCCB_IDX_CNT, rd_val);
            chk_in("prescaled count", 64 >> s, (66 >> s) + 1, rd_val);
        end
        // A burst on a neighbouring pin must not count
        for (int p = 0; p < 4; p++) begin
            for (int e = 0; e < 4; e++) begin
                bus_wr(`TCCB_IDX_CCR, 2'h1, 16'(4 + p + 8 * e));
                bus_wr(`TCCB_IDX_CNT, 2'h3, 16'h0000);
                tccb_ext_clk_model_i.burst((p + 1) % 4, 2, 2);
                tccb_ext_clk_model_i.burst(p, 3, 5 - e);
                repeat (8) @(posedge clk);
                bus_rd(`TCCB_IDX_CNT, rd_val);
                chk16("external edge count", (e > 1) ? 16'h0006 : 16'h0003, rd_val);
            end
        end
        for (int k = 0; k < 2; k++) begin
            bus_wr(5'(`TCCB_IDX_GRA + 1 + 5 * k), 2'h3, 16'(3 + 4 * k));
            bus_wr(5'h01, 2'h1, 16'(32 << k));
            bus_wr(5'(`TCCB_IDX_CNT + 1), 2'h3, 16'h0000);
            m0 = (k == 0) ? na1 : nb1;
            repeat (80) @(posedge clk);
            chk_in("match pulses", (20 >> k) - 1, (20 >> k) + 1, 16'(((k == 0) ? na1 : nb1) - m0));
        end
        @(posedge clk);
        ph_en <= 1'b1;
        bus_wr(5'h02, 2'h1, 16'h0000);
        bus_wr(5'(`TCCB_IDX_CNT + 2), 2'h3, 16'h0100);
        for (int i = 0; i < 5; i++) begin
            step(i < 3 || i == 4, i >= 3);
        end
        repeat (10) @(posedge clk);
        chk_rd("phase count", 5'(`TCCB_IDX_CNT + 2), 16'h0102);
        @(posedge clk);
        buf_en <= 4'b1001;
        for (int c = 3; c < 5; c++) begin
            bus_wr(5'(c), 2'h1, 16'h0004);
            for (int b = 0; b < 2; b++) begin
                bus_wr(5'(`TCCB_IDX_BUF_A3 + 2 * (c - 3) + b), 2'h3, 16'(16'h0040 + b));
                bus_wr(5'(`TCCB_IDX_GRA + c + 5 * b), 2'h3, 16'(16'h0010 + b));
                bus_wr(5'(`TCCB_IDX_CNT + c), 2'h3, 16'(16'h0010 + b));
                repeat (3) @(posedge clk);
                chk_rd("reload", 5'(`TCCB_IDX_GRA + c + 5 * b), 16'((b == c - 3) ? 16'h0040 + b : 16'h0010 + b));
            end
        end
        @(posedge clk);
        buf_en <= 4'b1101;
        gra_cap <= 5'h10;
        grb_cap <= 5'h10;
        bus_wr(5'(`TCCB_IDX_GRA + 4), 2'h3, 16'h0077);
        bus_wr(5'(`TCCB_IDX_CNT + 4), 2'h3, 16'h0033);
        @(posedge clk);
        cap_a <= 5'h10;
        cap_b <= 5'h10;
        @(posedge clk);
        cap_a <= 5'h00;
        cap_b <= 5'h00;
        chk_rd("capture buffer", `TCCB_IDX_BUF_A4, 16'h0077);
        chk_rd("captured count", 5'(`TCCB_IDX_GRA + 4), 16'h0033);
        chk_rd("capture buffer b", `TCCB_IDX_BUF_B4, 16'h0041);
        chk_rd("captured count b", 5'(`TCCB_IDX_GRB + 4), 16'h0033);
        @(posedge clk);
        gra_cap <= 5'h01;
        grb_cap <= 5'h00;
        sync_sel <= 5'h03;
        bus_wr(5'h00, 2'h1, 16'h0024);
        bus_wr(5'h01, 2'h1, 16'h0064);
        bus_wr(`TCCB_IDX_CNT, 2'h3, 16'h0050);
        bus_wr(5'(`TCCB_IDX_CNT + 1), 2'h3, 16'h0077);
        @(posedge clk);
        cap_a <= 5'h01;
        @(posedge clk);
        cap_a <= 5'h00;
        repeat (2) @(posedge clk);
        chk_rd("capture clear", `TCCB_IDX_CNT, 16'h0000);
        chk_rd("sync clear", 5'(`TCCB_IDX_CNT + 1), 16'h0000);
        chk_rd("captured value", `TCCB_IDX_GRA, 16'h0050);
        @(posedge clk);
        standby <= 1'b1;
        @(posedge clk);
        standby <= 1'b0;
        buf_en <= 4'h0;
        gra_cap <= 5'h00;
        sync_sel <= 5'h00;
        ph_en <= 1'b0;
        chk_defaults();
        bus_wr(`TCCB_IDX_BUF_B3, 2'h3, 16'h1111);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        chk_defaults();
        results();
    end
endmodule : tb_top
`default_nettype wire
